// ### hdl/tariff_params.svh
// Constants shared by the tariff-period accumulation block
`ifndef TARIFF_PARAMS_SVH
`define TARIFF_PARAMS_SVH

// =====================================================================
// Storage sizes
`define NUM_CAL 20
`define NUM_SCHED 16
`define NUM_SLOTS 96
`define NUM_RATES 8
`define NUM_SEASONS 4
`define NUM_MONTHS 12
`define DAYS_PER_YEAR 366

// =====================================================================
// Data widths
`define ACC_W 32
`define AMT_W 16
`define CAL_DATA_W 10
`define CAL_ADDR_W 11

// =====================================================================
// Calendar field codes for the load and readback port
`define FLD_YEAR 3'h0
`define FLD_DAYMAP 3'h1
`define FLD_SLOT 3'h2
`define FLD_SEASON 3'h3
`define FLD_BILL 3'h4

// Field positions inside calendar data words
`define YEAR_VALID_BIT 7
`define SEASON_EN_BIT 9

// =====================================================================
// Freeze mode codes
`define FRZ_OFF 2'h0
`define FRZ_HOURLY 2'h1
`define FRZ_DAILY 2'h2
`define FRZ_WEEKLY 2'h3

// Totals readout kinds
`define TOT_SEASON 2'h0
`define TOT_MONTH 2'h1
`define TOT_FROZEN 2'h2

// Reset value and first day of the week for weekly freeze
`define ACC_RST 32'h0000_0000
`define FIRST_WEEKDAY 3'h0

`endif

// ### hdl/tariff_pkg.sv
// Types for the tariff-period accumulation block
package tariff_pkg;
`include "tariff_params.svh"

  // =====================================================================
  // Totals
  typedef logic [`ACC_W-1:0] acc_t;
  typedef acc_t [`NUM_RATES-1:0] totals_t;

  // Calendar date and time of day
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
    logic [2:0] weekday;
  } date_s;

  // Commands to and state of one bank of period totals
  typedef struct packed {
    logic add;
    logic close;
    logic clear;
    logic [2:0] rate;
    logic [`AMT_W-1:0] amount;
  } bank_ctl_s;

  typedef struct packed {
    totals_t cur;
    totals_t pri;
  } bank_state_s;

  // =====================================================================
  // Accumulator run state
  typedef enum logic [1:0] {
    RUN_IDLE,
    RUN_ACTIVE,
    RUN_HALT
  } run_e;

  typedef struct packed {
    run_e run;
    logic [4:0] active;
    logic [`NUM_CAL-1:0] valid;
    date_s last;
    logic [`NUM_SEASONS-1:0][`CAL_DATA_W-1:0] season_sh;
    logic [`NUM_MONTHS-1:0][4:0] bill_sh;
    logic [1:0] season_idx;
    totals_t frozen;
    acc_t tot_rdata;
    logic tot_rvalid;
    logic [`CAL_DATA_W-1:0] cal_rdata;
    logic cal_rvalid;
    logic season_pulse;
    logic month_pulse;
  } main_state_s;

endpackage : tariff_pkg

// ### hdl/period_bank.sv
// One set of current and prior per-rate totals for one period kind
`timescale 1ns/1ps
`include "tariff_params.svh"

module period_bank (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Commands
  input wire tariff_pkg::bank_ctl_s i_ctl,
  // Totals
  output tariff_pkg::totals_t o_cur,
  output tariff_pkg::totals_t o_pri
);
  import tariff_pkg::*;

  bank_state_s st_reg;
  bank_state_s st_next;

  // =====================================================================
  // Close copies, clear wipes only the current set
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < `NUM_RATES; i++) begin
      if (i_ctl.close) begin
        st_next.pri[i] = st_reg.cur[i]; // see [R14]
      end
      if (i_ctl.close || i_ctl.clear) begin
        st_next.cur[i] = `ACC_RST; // see [R14] see [R18] see [R19]
      end
      // Energy in a closing cycle lands in the new period
      if (i_ctl.add && (i_ctl.rate == 3'(i))) begin
        st_next.cur[i] = st_next.cur[i] + {{(`ACC_W-`AMT_W){1'b0}}, i_ctl.amount}; // see [R5]
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_cur = st_reg.cur;
  assign o_pri = st_reg.pri;

endmodule : period_bank

// ### hdl/tariff_period_energy_accumulator.sv
// Tariff-period energy accumulator: calendars, rate lookup and period control
//
// Summary of operation
// [R1] Store twenty yearly calendars, read back singly
// [R2] Sixteen day schedules per calendar
// [R3] Date picks one schedule per day
// [R4] Fifteen-minute slots cover the whole day
// [R5] Add energy to the slot's rate total
// [R6] Four seasons; hourly, daily, weekly frozen totals
// [R7] Separate monthly billing totals in parallel
// [R8] Start date ends previous period, spans years
// [R9] Season closes at midnight before next start
// [R10] Month closes at billing-day midnight
// [R11] No next-year calendar: halt at year end
// [R12] Next-year calendar: continue to next boundary
// [R13] Switch to new year's calendar at boundary
// [R14] Period end: copy to prior, clear, resume
// [R15] Prior and current totals always readable
// [R16] Calendar writes never pause accumulation
// [R17] Replaced calendar takes effect at period end
// [R18] Reset clears current, reloads end dates; ignored unless the next run state is RUN_ACTIVE
// [R19] Prior totals are cleared only by i_rst
// [R20] Software resets totals after replacing calendar
// [R21] Slot is hour times four plus quarter
`timescale 1ns/1ps
`include "tariff_params.svh"

module tariff_period_energy_accumulator (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Time and date source
  input wire logic i_tick,
  input wire tariff_pkg::date_s i_date,
  // Metered energy
  input wire logic i_energy_valid,
  input wire logic [`AMT_W-1:0] i_energy_amount,
  // Accumulation control
  input wire logic i_acc_reset,
  input wire logic [1:0] i_freeze_mode,
  // Calendar load and readback
  input wire logic i_cal_wr,
  input wire logic i_cal_rd,
  input wire logic [4:0] i_cal_sel,
  input wire logic [2:0] i_cal_field,
  input wire logic [`CAL_ADDR_W-1:0] i_cal_addr,
  input wire logic [`CAL_DATA_W-1:0] i_cal_wdata,
  output logic [`CAL_DATA_W-1:0] o_cal_rdata,
  output logic o_cal_rvalid,
  // Totals readout
  input wire logic i_tot_rd,
  input wire logic [1:0] i_tot_kind,
  input wire logic i_tot_prior,
  input wire logic [2:0] i_tot_rate,
  output tariff_pkg::acc_t o_tot_rdata,
  output logic o_tot_rvalid,
  // Status
  output logic o_running,
  output logic o_halted,
  output logic [4:0] o_active_cal,
  output logic [1:0] o_season_idx,
  output logic o_season_closed,
  output logic o_month_closed
);
  import tariff_pkg::*;

  // =====================================================================
  // Calendar memories, kept out of reset on purpose: only the valid
  // flags need a defined value, stale contents reach only readback and calendars whose valid flag is set
  logic [6:0] year_mem [`NUM_CAL];
  logic [3:0] daymap_mem [`NUM_CAL][`DAYS_PER_YEAR];
  logic [2:0] slot_mem [`NUM_CAL][`NUM_SCHED][`NUM_SLOTS];
  logic [`CAL_DATA_W-1:0] season_mem [`NUM_CAL][`NUM_SEASONS];
  logic [4:0] bill_mem [`NUM_CAL][`NUM_MONTHS];

  main_state_s r_reg;
  main_state_s r_next;
  bank_ctl_s season_ctl;
  bank_ctl_s month_ctl;
  totals_t season_cur;
  totals_t season_pri;
  totals_t month_cur;
  totals_t month_pri;

  // Address fields of the calendar port
  logic sel_ok;
  logic [8:0] wr_doy;
  logic [3:0] wr_sched;
  logic [6:0] wr_slot;
  logic [1:0] wr_season;
  logic [3:0] wr_month;

  // =====================================================================
  // Day of year, zero based, leap years every fourth year
  function automatic logic [8:0] day_of_year(input date_s d);
    logic [8:0] cum;
    logic leap_add;
    cum = 9'h000;
    leap_add = (d.year[1:0] == 2'h0) && (d.month > 4'h2);
    case (d.month)
      4'h1: cum = 9'h000;
      4'h2: cum = 9'h01f;
      4'h3: cum = 9'h03b;
      4'h4: cum = 9'h05a;
      4'h5: cum = 9'h078;
      4'h6: cum = 9'h097;
      4'h7: cum = 9'h0b5;
      4'h8: cum = 9'h0d4;
      4'h9: cum = 9'h0f3;
      4'ha: cum = 9'h111;
      4'hb: cum = 9'h130;
      4'hc: cum = 9'h14e;
      default: cum = 9'h000;
    endcase
    return cum + {4'h0, d.day} - 9'h001 + {8'h00, leap_add}; // see [R3]
  endfunction : day_of_year

  // Slot 0..95 from hour and quarter hour
  function automatic logic [6:0] slot_index(input date_s d);
    logic [1:0] quarter;
    quarter = (d.minute >= 6'h2d) ? 2'h3 : (d.minute >= 6'h1e) ? 2'h2 : (d.minute >= 6'h0f) ? 2'h1 : 2'h0;
    return {d.hour, 2'b00} + {5'h00, quarter}; // see [R4] see [R21]
  endfunction : slot_index

  // =====================================================================
  // Calendar port address split
  assign sel_ok = (i_cal_sel < `NUM_CAL);
  assign wr_doy = i_cal_addr[8:0];
  assign wr_sched = i_cal_addr[10:7];
  assign wr_slot = i_cal_addr[6:0];
  assign wr_season = i_cal_addr[1:0];
  assign wr_month = i_cal_addr[3:0];

  // Calendar writes go straight to storage, independent of accumulation
  always_ff @(posedge i_mclk) begin
    if (i_cal_wr && sel_ok) begin // see [R1] see [R16]
      case (i_cal_field)
        `FLD_YEAR: begin
          year_mem[i_cal_sel] <= i_cal_wdata[6:0];
        end
        `FLD_DAYMAP: begin
          if (wr_doy < `DAYS_PER_YEAR) begin
            daymap_mem[i_cal_sel][wr_doy] <= i_cal_wdata[3:0]; // see [R2] see [R3]
          end
        end
        `FLD_SLOT: begin
          if (wr_slot < `NUM_SLOTS) begin
            slot_mem[i_cal_sel][wr_sched][wr_slot] <= i_cal_wdata[2:0]; // see [R4]
          end
        end
        `FLD_SEASON: begin
          season_mem[i_cal_sel][wr_season] <= i_cal_wdata; // see [R6] see [R8]
        end
        `FLD_BILL: begin
          if (wr_month < `NUM_MONTHS) begin
            bill_mem[i_cal_sel][wr_month] <= i_cal_wdata[4:0]; // see [R7] see [R8]
          end
        end
        default: begin
        end
      endcase
    end
  end

  // =====================================================================
  // Next-state logic
  always_comb begin
    logic found;
    logic [4:0] found_idx;
    logic [4:0] load_idx;
    logic [3:0] sched;
    logic [2:0] rate;
    logic new_day;
    logic new_hour;
    logic new_year;
    logic season_hit;
    logic [1:0] season_hit_idx;
    logic month_hit;
    logic [4:0] bill_day;
    logic load_season;
    logic load_month;
    logic acc_on;
    logic freeze;
    found = 1'b0;
    found_idx = 5'h00;
    load_idx = r_reg.active;
    sched = 4'h0;
    rate = 3'h0;
    season_hit = 1'b0;
    season_hit_idx = 2'h0;
    month_hit = 1'b0;
    bill_day = 5'h00;
    load_season = 1'b0;
    load_month = 1'b0;
    freeze = 1'b0;
    new_day = 1'b0;
    new_hour = 1'b0;
    new_year = 1'b0;
    acc_on = 1'b0;
    r_next = r_reg;
    r_next.tot_rvalid = 1'b0;
    r_next.cal_rvalid = 1'b0;
    r_next.season_pulse = 1'b0;
    r_next.month_pulse = 1'b0;
    season_ctl = '0;
    month_ctl = '0;

    // Calendar for the present year, lowest slot wins
    for (int i = 0; i < `NUM_CAL; i++) begin
      if (!found && r_reg.valid[i] && (year_mem[i] == i_date.year)) begin
        found = 1'b1;
        found_idx = 5'(i);
      end
    end

    // Rate of the present slot from the calendar in use
    sched = daymap_mem[r_reg.active][day_of_year(i_date)]; // see [R3]
    rate = slot_mem[r_reg.active][sched][slot_index(i_date)]; // see [R5]

    // Date transitions seen on a time tick
    new_year = i_tick && (i_date.year != r_reg.last.year);
    new_day = i_tick && ({i_date.year, i_date.month, i_date.day} !=
                         {r_reg.last.year, r_reg.last.month, r_reg.last.day});
    new_hour = i_tick && (new_day || (i_date.hour != r_reg.last.hour));
    if (i_tick) begin
      r_next.last = i_date;
    end

    // Boundaries compare against dates latched at period start, so a
    // replaced calendar cannot move the end of the running period
    for (int s = 0; s < `NUM_SEASONS; s++) begin
      if (r_reg.season_sh[s][`SEASON_EN_BIT] && (r_reg.season_sh[s][8:5] == i_date.month) &&
          (r_reg.season_sh[s][4:0] == i_date.day)) begin
        season_hit = new_day; // see [R9] see [R17]
        season_hit_idx = 2'(s);
      end
    end
    if ((i_date.month != 4'h0) && (i_date.month <= `NUM_MONTHS)) begin
      bill_day = r_reg.bill_sh[4'(i_date.month - 4'h1)];
    end
    month_hit = new_day && (bill_day != 5'h00) && (bill_day == i_date.day); // see [R10] see [R17]

    // Run control
    case (r_reg.run)
      RUN_IDLE, RUN_HALT: begin
        if (i_tick && found) begin
          r_next.run = RUN_ACTIVE;
          r_next.active = found_idx;
          load_idx = found_idx;
          load_season = 1'b1;
          load_month = 1'b1;
        end
      end
      RUN_ACTIVE: begin
        if (new_year && !found) begin
          r_next.run = RUN_HALT; // see [R11]
        end else begin
          if (season_hit) begin
            season_ctl.close = 1'b1; // see [R8] see [R14]
            r_next.season_idx = season_hit_idx;
            r_next.season_pulse = 1'b1;
            load_season = 1'b1;
          end
          if (month_hit) begin
            month_ctl.close = 1'b1; // see [R8] see [R14]
            r_next.month_pulse = 1'b1;
            load_month = 1'b1;
          end
          if (new_year) begin
            // Running periods carry over into the new year
            r_next.active = found_idx; // see [R12] see [R13]
            load_idx = found_idx;
            load_season = 1'b1;
            load_month = 1'b1;
          end
        end
      end
      default: begin
        r_next.run = RUN_IDLE;
      end
    endcase

    // Reset command: current only, end dates from the present year's calendar if one is valid
    if (i_acc_reset && (r_next.run == RUN_ACTIVE)) begin
      season_ctl.clear = 1'b1; // see [R18] see [R19]
      month_ctl.clear = 1'b1; // see [R18]
      if (found) begin
        r_next.active = found_idx;
        load_idx = found_idx;
      end
      load_season = 1'b1;
      load_month = 1'b1;
    end

    // Latch the end dates of the new period
    for (int s = 0; s < `NUM_SEASONS; s++) begin
      if (load_season) begin
        r_next.season_sh[s] = season_mem[load_idx][s]; // see [R14] see [R17]
      end
    end
    for (int m = 0; m < `NUM_MONTHS; m++) begin
      if (load_month) begin
        r_next.bill_sh[m] = bill_mem[load_idx][m]; // see [R14] see [R17]
      end
    end

    // Energy goes to both period kinds while running
    acc_on = (r_reg.run == RUN_ACTIVE) && (r_next.run == RUN_ACTIVE);
    season_ctl.add = acc_on && i_energy_valid; // see [R5] see [R6] see [R16]
    season_ctl.rate = rate;
    season_ctl.amount = i_energy_amount;
    month_ctl.add = acc_on && i_energy_valid; // see [R5] see [R7]
    month_ctl.rate = rate;
    month_ctl.amount = i_energy_amount;

    // Frozen snapshot of the current season totals
    case (i_freeze_mode)
      `FRZ_HOURLY: freeze = new_hour;
      `FRZ_DAILY: freeze = new_day;
      `FRZ_WEEKLY: freeze = new_day && (i_date.weekday == `FIRST_WEEKDAY);
      default: freeze = 1'b0;
    endcase
    if (freeze) begin
      r_next.frozen = season_cur; // see [R6]
    end

    // Calendar valid flags follow the year word
    if (i_cal_wr && sel_ok && (i_cal_field == `FLD_YEAR)) begin
      r_next.valid[i_cal_sel] = i_cal_wdata[`YEAR_VALID_BIT]; // see [R1]
    end

    // Calendar readback, one word per request
    if (i_cal_rd) begin
      r_next.cal_rvalid = 1'b1; // see [R1]
      r_next.cal_rdata = '0;
      if (sel_ok) begin
        case (i_cal_field)
          `FLD_YEAR: r_next.cal_rdata = {2'b00, r_reg.valid[i_cal_sel], year_mem[i_cal_sel]};
          `FLD_DAYMAP: begin
            if (wr_doy < `DAYS_PER_YEAR) begin
              r_next.cal_rdata = {6'h00, daymap_mem[i_cal_sel][wr_doy]};
            end
          end
          `FLD_SLOT: begin
            if (wr_slot < `NUM_SLOTS) begin
              r_next.cal_rdata = {7'h00, slot_mem[i_cal_sel][wr_sched][wr_slot]};
            end
          end
          `FLD_SEASON: r_next.cal_rdata = season_mem[i_cal_sel][wr_season];
          `FLD_BILL: begin
            if (wr_month < `NUM_MONTHS) begin
              r_next.cal_rdata = {5'h00, bill_mem[i_cal_sel][wr_month]};
            end
          end
          default: begin
            r_next.cal_rdata = '0;
          end
        endcase
      end
    end

    // Totals readout, available in any run state
    if (i_tot_rd) begin
      r_next.tot_rvalid = 1'b1; // see [R15]
      case (i_tot_kind)
        `TOT_SEASON: r_next.tot_rdata = i_tot_prior ? season_pri[i_tot_rate] : season_cur[i_tot_rate];
        `TOT_MONTH: r_next.tot_rdata = i_tot_prior ? month_pri[i_tot_rate] : month_cur[i_tot_rate];
        `TOT_FROZEN: r_next.tot_rdata = r_reg.frozen[i_tot_rate];
        default: r_next.tot_rdata = `ACC_RST;
      endcase
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      r_reg <= '0;
      r_reg.run <= RUN_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // =====================================================================
  // Seasonal and monthly totals
  period_bank u_season_bank (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ctl(season_ctl),
    .o_cur(season_cur),
    .o_pri(season_pri)
  );

  period_bank u_month_bank (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ctl(month_ctl),
    .o_cur(month_cur),
    .o_pri(month_pri)
  );

  // =====================================================================
  // Outputs, all straight from the state register
  assign o_cal_rdata = r_reg.cal_rdata;
  assign o_cal_rvalid = r_reg.cal_rvalid;
  assign o_tot_rdata = r_reg.tot_rdata;
  assign o_tot_rvalid = r_reg.tot_rvalid;
  assign o_running = (r_reg.run == RUN_ACTIVE);
  assign o_halted = (r_reg.run == RUN_HALT);
  assign o_active_cal = r_reg.active;
  assign o_season_idx = r_reg.season_idx;
  assign o_season_closed = r_reg.season_pulse;
  assign o_month_closed = r_reg.month_pulse;

endmodule : tariff_period_energy_accumulator

// ### verif/tariff_period_energy_accumulator_properties.sv
// Port-level concurrent checks for the tariff-period accumulator
`timescale 1ns/1ps
`include "tariff_params.svh"

module tariff_props (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Watched inputs
  input wire logic i_tick,
  input wire logic i_cal_rd,
  input wire logic [4:0] i_cal_sel,
  input wire logic i_tot_rd,
  input wire logic [1:0] i_tot_kind,
  // Watched outputs
  input wire logic [`CAL_DATA_W-1:0] o_cal_rdata,
  input wire logic o_cal_rvalid,
  input wire tariff_pkg::acc_t o_tot_rdata,
  input wire logic o_tot_rvalid,
  input wire logic o_running,
  input wire logic o_halted,
  input wire logic o_season_closed,
  input wire logic o_month_closed
);
  import tariff_pkg::*;

  // ===================================================================
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ===================================================================
  // Readback ports
  cal_read_answer_a: assert property (i_cal_rd |=> o_cal_rvalid)
    else $error("calendar read not answered");
  cal_read_quiet_a: assert property (!i_cal_rd |=> !o_cal_rvalid)
    else $error("calendar answer without request");
  cal_bad_sel_a: assert property (i_cal_rd && i_cal_sel >= 5'h14 |=> o_cal_rdata == '0)
    else $error("out of range calendar read not zero");
  tot_read_answer_a: assert property (i_tot_rd |=> o_tot_rvalid)
    else $error("totals read not answered");
  tot_read_quiet_a: assert property (!i_tot_rd |=> !o_tot_rvalid)
    else $error("totals answer without request");
  tot_bad_kind_a: assert property (i_tot_rd && i_tot_kind == 2'h3 |=> o_tot_rdata == '0)
    else $error("unused totals kind not zero");

  // ===================================================================
  // Period control; closes only follow a date tick while running
  season_close_a: assert property (o_season_closed |-> $past(i_tick) && $past(o_running))
    else $error("season close without running tick");
  season_pulse_a: assert property (o_season_closed |=> !o_season_closed)
    else $error("season close pulse too long");
  month_close_a: assert property (o_month_closed |-> $past(i_tick) && $past(o_running))
    else $error("month close without running tick");
  run_halt_excl_a: assert property (!(o_running && o_halted))
    else $error("running and halted together");
  halt_entry_a: assert property ($rose(o_halted) |-> $past(i_tick) && $past(o_running))
    else $error("halt entered off a running tick");
  run_entry_a: assert property ($rose(o_running) |-> $past(i_tick))
    else $error("run started without tick");

  // Main scenarios reached
  season_seen_c: cover property (o_season_closed);
  month_seen_c: cover property (o_month_closed);
  halt_seen_c: cover property ($rose(o_halted));
endmodule : tariff_props

bind tariff_period_energy_accumulator tariff_props chk_u (.i_mclk, .i_rst, .i_tick, .i_cal_rd, .i_cal_sel,
  .i_tot_rd, .i_tot_kind, .o_cal_rdata, .o_cal_rvalid, .o_tot_rdata, .o_tot_rvalid, .o_running, .o_halted,
  .o_season_closed, .o_month_closed);

// ### verif/tb_tariff_period_energy_accumulator.sv
// Self-checking bench for the tariff-period accumulator
`timescale 1ns/1ps
`include "tariff_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_tariff_period_energy_accumulator;
  import tariff_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_tick = 0, i_energy_valid = 0, i_acc_reset = 0;
  logic i_cal_wr = 0, i_cal_rd = 0, i_tot_rd = 0, i_tot_prior = 0;
  date_s i_date = '0;
  logic [`AMT_W-1:0] i_energy_amount = '0;
  logic [1:0] i_freeze_mode = `FRZ_HOURLY, i_tot_kind = '0;
  logic [4:0] i_cal_sel = '0;
  logic [2:0] i_cal_field = '0, i_tot_rate = '0;
  logic [`CAL_ADDR_W-1:0] i_cal_addr = '0;
  logic [`CAL_DATA_W-1:0] i_cal_wdata = '0, o_cal_rdata;
  logic o_cal_rvalid, o_tot_rvalid, o_running, o_halted, o_season_closed, o_month_closed;
  acc_t o_tot_rdata;
  logic [4:0] o_active_cal;
  logic [1:0] o_season_idx;
  int bad_count = 0, tests_run = 0, cyc = 0, ph = 0, fz[8] = '{default: 0};
  // Reference totals: season and month, current and prior
  int scur[8] = '{default: 0}, spri[8] = '{default: 0}, mcur[8] = '{default: 0}, mpri[8] = '{default: 0};
  logic [31:0] seed = 32'd82746;

  // ===================================================================
  // Clock and device
  always #12.5 i_mclk = ~i_mclk;

  tariff_period_energy_accumulator dut_u (.i_mclk, .i_rst, .i_tick, .i_date, .i_energy_valid,
    .i_energy_amount, .i_acc_reset, .i_freeze_mode, .i_cal_wr, .i_cal_rd, .i_cal_sel, .i_cal_field,
    .i_cal_addr, .i_cal_wdata, .o_cal_rdata, .o_cal_rvalid, .i_tot_rd, .i_tot_kind, .i_tot_prior,
    .i_tot_rate, .o_tot_rdata, .o_tot_rvalid, .o_running, .o_halted, .o_active_cal, .o_season_idx,
    .o_season_closed, .o_month_closed);

  // ===================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
  endfunction : lfsr

  // Schedule 15 is shifted so a wrong schedule pick shows up
  function automatic int rate_of(input int sch, input int slot);
    return (sch == 15) ? (slot + 3) % 8 : slot % 8;
  endfunction : rate_of

  task automatic tally_and_finish();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cal_op(input logic wr, input logic [4:0] sel, input logic [2:0] fld,
                        input logic [10:0] addr, input logic [9:0] data);
    @(posedge i_mclk);
    i_cal_wr <= wr;
    i_cal_rd <= !wr;
    i_cal_sel <= sel;
    i_cal_field <= fld;
    i_cal_addr <= addr;
    i_cal_wdata <= data;
    @(posedge i_mclk);
    i_cal_wr <= 1'b0;
    i_cal_rd <= 1'b0;
    #1;
  endtask : cal_op

  task automatic cal_chk(input logic [4:0] sel, input logic [2:0] fld, input logic [10:0] addr,
                         input logic [9:0] exp);
    cal_op(1'b0, sel, fld, addr, 10'h0);
    `CHK(o_cal_rvalid, 1'b1)
    `CHK(o_cal_rdata, exp)
  endtask : cal_chk

  task automatic tot_chk(input logic [1:0] kind, input logic prior, input logic [2:0] rate, input int exp);
    @(posedge i_mclk);
    i_tot_rd <= 1'b1;
    i_tot_kind <= kind;
    i_tot_prior <= prior;
    i_tot_rate <= rate;
    @(posedge i_mclk);
    i_tot_rd <= 1'b0;
    #1;
    `CHK(o_tot_rvalid, 1'b1)
    `CHK(o_tot_rdata, acc_t'(exp))
  endtask : tot_chk

  task automatic check_all();
    for (int r = 0; r < 8; r++) begin
      tot_chk(2'h0, 1'b0, 3'(r), scur[r]);
      tot_chk(2'h0, 1'b1, 3'(r), spri[r]);
      tot_chk(2'h1, 1'b0, 3'(r), mcur[r]);
      tot_chk(2'h1, 1'b1, 3'(r), mpri[r]);
      tot_chk(2'h2, 1'b0, 3'(r), fz[r]);
    end
  endtask : check_all

  // One tick with a new date, energy alongside when asked
  task automatic step(input int y, input int m, input int d, input int h, input int mi, input logic ev,
                      input logic [15:0] amt);
    @(posedge i_mclk);
    i_tick <= 1'b1;
    i_date <= '{year: 7'(y), month: 4'(m), day: 5'(d), hour: 5'(h), minute: 6'(mi), second: 6'h0,
                weekday: 3'h0};
    i_energy_valid <= ev;
    i_energy_amount <= amt;
    @(posedge i_mclk);
    i_tick <= 1'b0;
    i_energy_valid <= 1'b0;
    #1;
  endtask : step

  // Hang guard, far above the run's length
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ===================================================================
  // Main sequence
  initial begin
    int h, mi, amt, r;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    cal_op(1'b1, 5'd0, `FLD_YEAR, 11'h0, 10'h081);
    for (int s = 0; s < 96; s++) begin
      cal_op(1'b1, 5'd0, `FLD_SLOT, {4'h0, 7'(s)}, 10'(rate_of(0, s)));
      cal_op(1'b1, 5'd0, `FLD_SLOT, {4'hf, 7'(s)}, 10'(rate_of(15, s)));
    end
    for (int d = 0; d < 12; d++) cal_op(1'b1, 5'd0, `FLD_DAYMAP, 11'(d), (d == 1) ? 10'hf : 10'h0);
    for (int s = 0; s < 4; s++) cal_op(1'b1, 5'd0, `FLD_SEASON, 11'(s), (s == 1) ? 10'h223 : 10'h0);
    for (int m = 0; m < 12; m++) cal_op(1'b1, 5'd0, `FLD_BILL, 11'(m), (m == 0) ? 10'h6 : 10'h0);
    cal_chk(5'd0, `FLD_YEAR, 11'h0, 10'h081);
    cal_chk(5'd0, `FLD_SLOT, {4'hf, 7'd10}, 10'h5);
    cal_chk(5'd0, `FLD_DAYMAP, 11'h1, 10'hf);
    cal_chk(5'd20, `FLD_YEAR, 11'h0, 10'h0);
    // Energy on the starting tick must be dropped
    step(1, 1, 1, 0, 0, 1'b1, 16'h55);
    `CHK(o_running, 1'b1)
    `CHK(o_active_cal, 5'd0)
    for (int d = 1; d <= 8; d++) begin
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        h = seed[4:0] % 24;
        mi = seed[10:5] % 60;
        amt = seed[31:16];
        if (h != ph || (k == 0 && d > 1)) fz = scur;
        ph = h;
        // Closing-cycle energy lands in the new period
        if (k == 0 && d == 3) begin
          spri = scur;
          scur = '{default: 0};
        end
        if (k == 0 && (d == 6 || d == 8)) begin
          mpri = mcur;
          mcur = '{default: 0};
        end
        r = rate_of((d == 2) ? 15 : 0, h * 4 + mi / 15);
        scur[r] += amt;
        mcur[r] += amt;
        step(1, 1, d, h, mi, 1'b1, 16'(amt));
        if (k == 0 && d == 3) `CHK(o_season_closed, 1'b1)
        if (k == 0 && d == 3) `CHK(o_season_idx, 2'h1)
        if (k == 0 && (d == 6 || d == 8)) `CHK(o_month_closed, 1'b1)
        if (k == 2 && d == 4) cal_op(1'b1, 5'd7, `FLD_YEAR, 11'h0, 10'h085);
        if (k == 3 && d == 4) cal_op(1'b1, 5'd0, `FLD_BILL, 11'h0, 10'h8);
      end
      check_all();
      if (d == 7) begin
        @(posedge i_mclk);
        i_acc_reset <= 1'b1;
        @(posedge i_mclk);
        i_acc_reset <= 1'b0;
        scur = '{default: 0};
        mcur = '{default: 0};
      end
    end
    // Year end with no calendar for the next year
    step(1, 12, 31, 0, 0, 1'b0, 16'h0);
    step(2, 1, 1, 0, 0, 1'b1, 16'h77);
    `CHK(o_halted, 1'b1)
    `CHK(o_running, 1'b0)
    step(2, 1, 1, 1, 0, 1'b1, 16'h99);
    fz = scur;
    check_all();
    cal_op(1'b1, 5'd3, `FLD_YEAR, 11'h0, 10'h082);
    step(2, 1, 1, 2, 0, 1'b0, 16'h0);
    `CHK(o_running, 1'b1)
    `CHK(o_active_cal, 5'd3)
    tot_chk(2'h3, 1'b0, 3'h0, 0);
    tally_and_finish();
  end
endmodule : tb_tariff_period_energy_accumulator
